// ---- src/obsp_params.svh ----
`ifndef OBSP_PARAMS_SVH
`define OBSP_PARAMS_SVH

// Interface type code reported in the interface control register
`define OBSP_PDI_TYPE        8'h80
// Byte offset of the interface control register
`define OBSP_PDI_CTRL_OFS    16'h0140
// Transfer size code of a single transfer
`define OBSP_SIZE_SINGLE     4'h0
// Default bus clock period in picoseconds (bench clock, asynchronous)
`define OBSP_BUS_PERIOD_PS   80000
// Default claimed address window, 64 Kbyte
`define OBSP_WINDOW_BASE     32'h0001_0000
`define OBSP_WINDOW_END      32'h0001_FFFF
// Reset value of data words
`define OBSP_WORD_RST        32'h0000_0000

`endif

// ---- src/obsp_pkg.sv ----
package obsp_pkg;

    typedef enum logic [1:0] {
        OBSP_B_IDLE,
        OBSP_B_PEND,
        OBSP_B_DONE
    } obsp_dev_state_t;

    typedef enum logic [1:0] {
        OBSP_H_IDLE,
        OBSP_H_ADDR,
        OBSP_H_DATA
    } obsp_host_state_t;

endpackage : obsp_pkg

// ---- src/obsp_if.sv ----
`timescale 1ns/1ns
interface obsp_if (
    // Bus clock and reset
    input wire logic bus_clk,
    input wire logic bus_rst
);
    logic [31:0] abus;
    logic        pa_valid;
    logic        rnw;
    logic [3:0]  be;
    logic [3:0]  size;
    logic [31:0] wr_dbus;
    logic        addr_ack;
    logic        wait_s;
    logic        wr_dack;
    logic        wr_comp;
    logic [31:0] rd_dbus;
    logic        rd_dack;
    logic        rd_comp;

    modport device (
        input  bus_clk, bus_rst, abus, pa_valid, rnw, be, size, wr_dbus,
        output addr_ack, wait_s, wr_dack, wr_comp, rd_dbus, rd_dack, rd_comp
    );

    modport host (
        input  bus_clk, bus_rst, addr_ack, wait_s, wr_dack, wr_comp, rd_dbus,
        input  rd_dack, rd_comp,
        output abus, pa_valid, rnw, be, size, wr_dbus
    );
endinterface : obsp_if

// ---- src/obsp_device.sv ----
// Function
// - Report interface type 0x80 at 0x0140
// - Fixed 32-bit data path with byte enables
// - Qualify every byte lane by enables
// - Master issues single transfers, size 0000
// - Window set by base and end parameters
// - Larger window means fewer decoded bits
// - Synchronous bus clock is aligned 25 MHz multiple
// - Asynchronous bus clock faster than core
// - Period parameter picks sync or async handling
// - Listed periods 40000 to 5000 ps are synchronous
`timescale 1ns/1ns
`include "obsp_params.svh"
module obsp_device
    import obsp_pkg::*;
#(
    parameter logic [31:0] window_base_param   = `OBSP_WINDOW_BASE,
    parameter logic [31:0] window_end_param    = `OBSP_WINDOW_END,
    parameter int          bus_period_ps_param = `OBSP_BUS_PERIOD_PS,
    parameter int          MEM_WORDS           = 1024
) (
    // Bus side, on the bus clock
    obsp_if.device      bus,
    // Core clock and reset
    input  wire logic   sys_clk,
    input  wire logic   sys_rst,
    // Core status
    output logic [7:0]  pdi_type_ff,
    output logic        sync_mode_ff,
    output logic        core_access_ff
);

    localparam int IDX_W = $clog2(MEM_WORDS);

    function automatic logic period_is_sync(input int p);
        return p inside {40000, 20000, 13333, 13334, 10000, 8000,
                         6666, 6667, 5714, 5715, 5000};
    endfunction : period_is_sync

    localparam logic SYNC_MODE = period_is_sync(bus_period_ps_param);

    // only bits above the window size are compared
    localparam logic [31:0] DEC_MASK = window_base_param ^ window_end_param;
    localparam logic [31:0] DEC_BASE = window_base_param & ~DEC_MASK;
    localparam logic [13:0] CTRL_IDX = 14'(`OBSP_PDI_CTRL_OFS >> 2);

    obsp_dev_state_t   state_ff;
    logic              req_tgl_ff;
    logic              rnw_q_ff;
    logic [3:0]        be_q_ff;
    logic [31:0]       off_q_ff;
    logic [31:0]       wdata_q_ff;
    logic              ack_seen_ff;
    logic              ack_sync;
    logic              addr_ack_ff;
    logic              wait_ff;
    logic              wr_dack_ff;
    logic              rd_dack_ff;
    logic [31:0]       rd_dbus_ff;
    logic              hit;

    logic              req_sync;
    logic              req_seen_ff;
    logic              ack_tgl_ff;
    logic [31:0]       rdata_core_ff;
    logic [31:0]       mem [MEM_WORDS];
    logic [31:0]       lane_mask;
    logic [31:0]       nxt_rdata;
    logic              core_go;

    assign hit = (bus.abus & ~DEC_MASK) == DEC_BASE;

    assign bus.addr_ack = addr_ack_ff;
    assign bus.wait_s   = wait_ff;
    assign bus.wr_dack  = wr_dack_ff;
    assign bus.wr_comp  = wr_dack_ff;
    assign bus.rd_dack  = rd_dack_ff;
    assign bus.rd_comp  = rd_dack_ff;
    assign bus.rd_dbus  = rd_dbus_ff;

    // Toggle crossings; aligned clocks need a single stage only
    generate
        if (SYNC_MODE) begin : g_sync
            logic ack_s1_ff;
            logic req_s1_ff;
            always_ff @(posedge bus.bus_clk or posedge bus.bus_rst) begin
                if (bus.bus_rst) begin
                    ack_s1_ff <= 1'b0;
                end else begin
                    ack_s1_ff <= ack_tgl_ff;
                end
            end
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    req_s1_ff <= 1'b0;
                end else begin
                    req_s1_ff <= req_tgl_ff;
                end
            end
            assign ack_sync = ack_s1_ff;
            assign req_sync = req_s1_ff;
        end else begin : g_async
            logic ack_s1_ff;
            logic ack_s2_ff;
            logic req_s1_ff;
            logic req_s2_ff;
            always_ff @(posedge bus.bus_clk or posedge bus.bus_rst) begin
                if (bus.bus_rst) begin
                    ack_s1_ff <= 1'b0;
                    ack_s2_ff <= 1'b0;
                end else begin
                    ack_s1_ff <= ack_tgl_ff;
                    ack_s2_ff <= ack_s1_ff;
                end
            end
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    req_s1_ff <= 1'b0;
                    req_s2_ff <= 1'b0;
                end else begin
                    req_s1_ff <= req_tgl_ff;
                    req_s2_ff <= req_s1_ff;
                end
            end
            assign ack_sync = ack_s2_ff;
            assign req_sync = req_s2_ff;
        end
    endgenerate

    // Bus side transfer sequencing
    always_ff @(posedge bus.bus_clk or posedge bus.bus_rst) begin
        if (bus.bus_rst) begin
            state_ff    <= OBSP_B_IDLE;
            req_tgl_ff  <= 1'b0;
            rnw_q_ff    <= 1'b0;
            be_q_ff     <= 4'h0;
            off_q_ff    <= `OBSP_WORD_RST;
            wdata_q_ff  <= `OBSP_WORD_RST;
            ack_seen_ff <= 1'b0;
            addr_ack_ff <= 1'b0;
            wait_ff     <= 1'b0;
            wr_dack_ff  <= 1'b0;
            rd_dack_ff  <= 1'b0;
            rd_dbus_ff  <= `OBSP_WORD_RST;
        end else begin
            unique case (state_ff)
                OBSP_B_IDLE: begin
                    if (bus.pa_valid && hit) begin
                        addr_ack_ff <= 1'b1;
                        wait_ff     <= 1'b1;
                        rnw_q_ff    <= bus.rnw;
                        be_q_ff     <= bus.be;
                        off_q_ff    <= bus.abus & DEC_MASK;
                        wdata_q_ff  <= bus.wr_dbus;
                        req_tgl_ff  <= ~req_tgl_ff;
                        state_ff    <= OBSP_B_PEND;
                    end
                end
                OBSP_B_PEND: begin
                    addr_ack_ff <= 1'b0;
                    if (ack_sync != ack_seen_ff) begin
                        ack_seen_ff <= ack_sync;
                        wait_ff     <= 1'b0;
                        rd_dack_ff  <= rnw_q_ff;
                        wr_dack_ff  <= ~rnw_q_ff;
                        rd_dbus_ff  <= rnw_q_ff ? rdata_core_ff : `OBSP_WORD_RST;
                        state_ff    <= OBSP_B_DONE;
                    end
                end
                OBSP_B_DONE: begin
                    rd_dack_ff <= 1'b0;
                    wr_dack_ff <= 1'b0;
                    rd_dbus_ff <= `OBSP_WORD_RST;
                    state_ff   <= OBSP_B_IDLE;
                end
            endcase
        end
    end

    // Request fields stay frozen while the toggle is in flight
    assign core_go = req_sync != req_seen_ff;

    // lane mask from the byte enables
    generate
        for (genvar i = 0; i < 4; i++) begin : g_lane
            assign lane_mask[8*i +: 8] = {8{be_q_ff[i]}};
        end
    endgenerate

    // control register overrides the memory word
    always_comb begin
        if (off_q_ff[15:2] == CTRL_IDX) begin
            nxt_rdata = {24'h00_0000, `OBSP_PDI_TYPE} & lane_mask;
        end else begin
            nxt_rdata = mem[off_q_ff[IDX_W+1:2]] & lane_mask;
        end
    end

    // Core side access and answer
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_seen_ff    <= 1'b0;
            ack_tgl_ff     <= 1'b0;
            rdata_core_ff  <= `OBSP_WORD_RST;
            core_access_ff <= 1'b0;
        end else begin
            core_access_ff <= core_go;
            if (core_go) begin
                req_seen_ff   <= req_sync;
                rdata_core_ff <= nxt_rdata;
                ack_tgl_ff    <= ~ack_tgl_ff;
            end
        end
    end

    // Memory write; control register is read only
    always_ff @(posedge sys_clk) begin
        if (core_go && !rnw_q_ff && off_q_ff[15:2] != CTRL_IDX) begin
            for (int i = 0; i < 4; i++) begin
                if (be_q_ff[i]) begin
                    mem[off_q_ff[IDX_W+1:2]][8*i +: 8] <= wdata_q_ff[8*i +: 8];
                end
            end
        end
    end

    // Core status outputs
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pdi_type_ff  <= 8'h00;
            sync_mode_ff <= 1'b0;
        end else begin
            pdi_type_ff  <= `OBSP_PDI_TYPE;
            sync_mode_ff <= SYNC_MODE;
        end
    end

endmodule : obsp_device

// ---- src/obsp_host.sv ----
`timescale 1ns/1ns
`include "obsp_params.svh"
module obsp_host
    import obsp_pkg::*;
(
    // Bus side, on the bus clock
    obsp_if.host        bus,
    // User clock and reset
    input  wire logic   sys_clk,
    input  wire logic   sys_rst,
    // Command
    input  wire logic   cmd_valid,
    input  wire logic   cmd_rnw,
    input  wire logic [31:0] cmd_addr,
    input  wire logic [3:0]  cmd_be,
    input  wire logic [31:0] cmd_wdata,
    output logic        cmd_ready_ff,
    // Response
    output logic        rsp_valid_ff,
    output logic [31:0] rsp_rdata_ff
);

    obsp_host_state_t  state_ff;
    logic              cmd_tgl_ff;
    logic              c_rnw_ff;
    logic [31:0]       c_addr_ff;
    logic [3:0]        c_be_ff;
    logic [31:0]       c_wdata_ff;
    logic              cmd_s1_ff;
    logic              cmd_s2_ff;
    logic              cmd_seen_ff;
    logic              done_tgl_ff;
    logic [31:0]       rdata_bus_ff;
    logic              done_s1_ff;
    logic              done_s2_ff;
    logic              done_seen_ff;
    logic              pa_valid_ff;
    logic [31:0]       abus_ff;
    logic              rnw_ff;
    logic [3:0]        be_ff;
    logic [31:0]       wr_dbus_ff;

    assign bus.pa_valid = pa_valid_ff;
    assign bus.abus     = abus_ff;
    assign bus.rnw      = rnw_ff;
    assign bus.be       = be_ff;
    assign bus.size     = `OBSP_SIZE_SINGLE;
    assign bus.wr_dbus  = wr_dbus_ff;

    // User side command capture and response
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_ready_ff <= 1'b1;
            cmd_tgl_ff   <= 1'b0;
            c_rnw_ff     <= 1'b0;
            c_addr_ff    <= `OBSP_WORD_RST;
            c_be_ff      <= 4'h0;
            c_wdata_ff   <= `OBSP_WORD_RST;
            done_s1_ff   <= 1'b0;
            done_s2_ff   <= 1'b0;
            done_seen_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_rdata_ff <= `OBSP_WORD_RST;
        end else begin
            done_s1_ff   <= done_tgl_ff;
            done_s2_ff   <= done_s1_ff;
            rsp_valid_ff <= 1'b0;
            if (cmd_valid && cmd_ready_ff) begin
                cmd_ready_ff <= 1'b0;
                c_rnw_ff     <= cmd_rnw;
                c_addr_ff    <= cmd_addr;
                c_be_ff      <= cmd_be;
                c_wdata_ff   <= cmd_wdata;
                cmd_tgl_ff   <= ~cmd_tgl_ff;
            end
            if (done_s2_ff != done_seen_ff) begin
                done_seen_ff <= done_s2_ff;
                rsp_valid_ff <= 1'b1;
                rsp_rdata_ff <= rdata_bus_ff;
                cmd_ready_ff <= 1'b1;
            end
        end
    end

    // Bus side master sequencing
    always_ff @(posedge bus.bus_clk or posedge bus.bus_rst) begin
        if (bus.bus_rst) begin
            state_ff     <= OBSP_H_IDLE;
            cmd_s1_ff    <= 1'b0;
            cmd_s2_ff    <= 1'b0;
            cmd_seen_ff  <= 1'b0;
            done_tgl_ff  <= 1'b0;
            rdata_bus_ff <= `OBSP_WORD_RST;
            pa_valid_ff  <= 1'b0;
            abus_ff      <= `OBSP_WORD_RST;
            rnw_ff       <= 1'b0;
            be_ff        <= 4'h0;
            wr_dbus_ff   <= `OBSP_WORD_RST;
        end else begin
            cmd_s1_ff <= cmd_tgl_ff;
            cmd_s2_ff <= cmd_s1_ff;
            unique case (state_ff)
                OBSP_H_IDLE: begin
                    if (cmd_s2_ff != cmd_seen_ff) begin
                        cmd_seen_ff <= cmd_s2_ff;
                        pa_valid_ff <= 1'b1;
                        abus_ff     <= c_addr_ff;
                        rnw_ff      <= c_rnw_ff;
                        be_ff       <= c_be_ff;
                        wr_dbus_ff  <= c_wdata_ff;
                        state_ff    <= OBSP_H_ADDR;
                    end
                end
                OBSP_H_ADDR: begin
                    if (bus.addr_ack) begin
                        pa_valid_ff <= 1'b0;
                        state_ff    <= OBSP_H_DATA;
                    end
                end
                OBSP_H_DATA: begin
                    if (bus.rd_dack || bus.wr_dack) begin
                        rdata_bus_ff <= bus.rd_dack ? bus.rd_dbus : `OBSP_WORD_RST;
                        done_tgl_ff  <= ~done_tgl_ff;
                        state_ff     <= OBSP_H_IDLE;
                    end
                end
            endcase
        end
    end

endmodule : obsp_host

// ---- verification/obsp_chk.sv ----
`timescale 1ns/1ns
`include "obsp_params.svh"
module obsp_chk
    import obsp_pkg::*;
#(
    parameter logic [31:0] window_base_param = `OBSP_WINDOW_BASE,
    parameter logic [31:0] window_end_param  = `OBSP_WINDOW_END
) (
    // Bus clock and reset
    input wire logic        bus_clk,
    input wire logic        bus_rst,
    // Host request
    input wire logic [31:0] abus,
    input wire logic        pa_valid,
    input wire logic        rnw,
    input wire logic [3:0]  be,
    input wire logic [3:0]  size,
    // Device answer
    input wire logic        addr_ack,
    input wire logic        wait_s,
    input wire logic        wr_dack,
    input wire logic        wr_comp,
    input wire logic [31:0] rd_dbus,
    input wire logic        rd_dack,
    input wire logic        rd_comp
);
    localparam logic [31:0] MASK = window_base_param ^ window_end_param;
    logic [3:0]  be_ff;
    logic        rnw_ff;
    logic [31:0] lane_m;

    // Request is still held in the ack cycle, so latch it there
    always_ff @(posedge bus_clk or posedge bus_rst) begin
        if (bus_rst) begin
            be_ff  <= 4'h0;
            rnw_ff <= 1'b0;
        end else if (pa_valid && addr_ack) begin
            be_ff  <= be;
            rnw_ff <= rnw;
        end
    end
    assign lane_m = {{8{be_ff[3]}}, {8{be_ff[2]}}, {8{be_ff[1]}}, {8{be_ff[0]}}};

    default clocking cb @(posedge bus_clk); endclocking
    default disable iff (bus_rst);

    ack_in_window_a: assert property (addr_ack |-> $past(pa_valid)
        && (($past(abus) & ~MASK) == (window_base_param & ~MASK)))
        else $error("address ack without an in-window request");
    ack_one_pulse_a: assert property (addr_ack |=> !addr_ack)
        else $error("address ack longer than one cycle");
    wait_with_ack_a: assert property (addr_ack |-> wait_s)
        else $error("wait not raised with address ack");
    dack_bound_a: assert property (addr_ack |-> ##[1:30] (wr_dack || rd_dack))
        else $error("data ack missing after address ack");
    wait_drop_a: assert property ($fell(wait_s) |-> (wr_dack || rd_dack))
        else $error("wait dropped without data ack");
    comp_pair_a: assert property ((wr_comp == wr_dack) && (rd_comp == rd_dack))
        else $error("complete differs from data ack");
    dir_by_rnw_a: assert property ((wr_dack || rd_dack) |->
        (rd_dack == rnw_ff) && (wr_dack == !rnw_ff))
        else $error("data ack direction differs from request");
    lane_zero_a: assert property (rd_dack |-> (rd_dbus & ~lane_m) == 32'h0000_0000)
        else $error("disabled read lane not zero");
    rd_idle_a: assert property (!rd_dack |-> rd_dbus == 32'h0000_0000)
        else $error("read bus driven outside data ack");
    size_single_a: assert property (pa_valid |-> size == 4'h0)
        else $error("transfer size not single");
    ack_gap_a: assert property ((wr_dack || rd_dack) |=> !addr_ack [*2])
        else $error("new address ack too soon after data ack");
endmodule : obsp_chk

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
`include "obsp_params.svh"
module tb_top
    import obsp_pkg::*;
;
    localparam logic [31:0] BASE = `OBSP_WINDOW_BASE;
    logic        sys_clk   = 1'b0;
    logic        bus_clk   = 1'b0;
    logic        sys_rst   = 1'b1;
    logic        bus_rst   = 1'b1;
    logic        cmd_valid = 1'b0;
    logic        cmd_rnw   = 1'b0;
    logic [31:0] cmd_addr  = 32'h0000_0000;
    logic [3:0]  cmd_be    = 4'h0;
    logic [31:0] cmd_wdata = 32'h0000_0000;
    logic        cmd_ready_ff;
    logic        rsp_valid_ff;
    logic [31:0] rsp_rdata_ff;
    logic [7:0]  pdi_type_ff;
    logic        sync_mode_ff;
    logic        sync2_ff;
    logic        core_access_ff;
    logic [31:0] ref_m [4];
    logic [31:0] d;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cycles     = 0;
    int          n_xfer     = 0;
    int          n_acc      = 0;
    int          n_sync     = 0;

    always #50 sys_clk = ~sys_clk;
    always #40 bus_clk = ~bus_clk;

    obsp_if u_if (.bus_clk(bus_clk), .bus_rst(bus_rst));
    obsp_device u_obsp_device (.bus(u_if.device), .sys_clk(sys_clk), .sys_rst(sys_rst),
        .pdi_type_ff(pdi_type_ff), .sync_mode_ff(sync_mode_ff),
        .core_access_ff(core_access_ff));
    obsp_host u_obsp_host (.bus(u_if.host), .sys_clk(sys_clk), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_rnw(cmd_rnw), .cmd_addr(cmd_addr), .cmd_be(cmd_be),
        .cmd_wdata(cmd_wdata), .cmd_ready_ff(cmd_ready_ff), .rsp_valid_ff(rsp_valid_ff),
        .rsp_rdata_ff(rsp_rdata_ff));
    obsp_chk #(.window_base_param(`OBSP_WINDOW_BASE), .window_end_param(`OBSP_WINDOW_END))
    u_obsp_chk (.bus_clk(bus_clk), .bus_rst(bus_rst), .abus(u_if.abus),
        .pa_valid(u_if.pa_valid), .rnw(u_if.rnw), .be(u_if.be), .size(u_if.size),
        .addr_ack(u_if.addr_ack), .wait_s(u_if.wait_s), .wr_dack(u_if.wr_dack),
        .wr_comp(u_if.wr_comp), .rd_dbus(u_if.rd_dbus), .rd_dack(u_if.rd_dack),
        .rd_comp(u_if.rd_comp));

    // Aligned-clock instance listens to the same requests
    // aligned rising edges
    obsp_if u_if2 (.bus_clk(sys_clk), .bus_rst(sys_rst));
    assign u_if2.abus     = u_if.abus;
    assign u_if2.pa_valid = u_if.pa_valid;
    assign u_if2.rnw      = u_if.rnw;
    assign u_if2.be       = u_if.be;
    assign u_if2.size     = u_if.size;
    assign u_if2.wr_dbus  = u_if.wr_dbus;
    obsp_device #(.bus_period_ps_param(13334)) u_obsp_device_sync (.bus(u_if2.device),
        .sys_clk(sys_clk), .sys_rst(sys_rst), .pdi_type_ff(), .sync_mode_ff(sync2_ff),
        .core_access_ff());

    // One core access and one aligned-clock answer per transfer
    always @(negedge sys_clk) begin
        if (core_access_ff === 1'b1) begin
            n_acc++;
        end
        if (u_if2.rd_dack === 1'b1 || u_if2.wr_dack === 1'b1) begin
            n_sync++;
        end
    end

    function automatic logic [31:0] lm(input logic [3:0] b);
        return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    endfunction : lm

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic stop_test();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    // Entered 10 ns after a sys_clk edge, leaves at the same phase
    task automatic xfer(input logic w, input logic [31:0] a, input logic [3:0] b,
                        input logic [31:0] wd, output logic [31:0] r);
        int n;
        n = 0;
        n_xfer++;
        cmd_valid = 1'b1;
        cmd_rnw   = w;
        cmd_addr  = a;
        cmd_be    = b;
        cmd_wdata = wd;
        @(posedge sys_clk);
        #10;
        cmd_valid = 1'b0;
        check({31'h0, cmd_ready_ff}, 32'h0000_0000);
        while (rsp_valid_ff !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            #10;
            n++;
        end
        if (n == 200) begin
            n_mismatch++;
        end
        r = rsp_rdata_ff;
        check({31'h0, cmd_ready_ff}, 32'h0000_0001);
    endtask : xfer

    task automatic wr(input logic [31:0] a, input logic [3:0] b, input logic [31:0] wd);
        logic [31:0] r;
        xfer(1'b0, a, b, wd, r);
        // Words above the memory depth alias onto the low words
        if (a[31:16] == BASE[31:16] && a[11:4] == 8'h00) begin
            ref_m[a[3:2]] = (ref_m[a[3:2]] & ~lm(b)) | (wd & lm(b));
        end
    endtask : wr

    task automatic rd_chk(input logic [31:0] a, input logic [3:0] b, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b1, a, b, 32'h0000_0000, r);
        check(r, e & lm(b));
    endtask : rd_chk

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        #10;
        sys_rst = 1'b0;
        // Bus reset released on a falling bus clock edge, away from the rising edge
        @(negedge bus_clk);
        bus_rst = 1'b0;
        @(posedge sys_clk);
        #10;
        check({24'h00_0000, pdi_type_ff}, 32'h0000_0080);
        check({31'h0, sync_mode_ff}, 32'h0000_0000);
        check({31'h0, sync2_ff}, 32'h0000_0001);
        rd_chk(BASE + 32'h0000_0140, 4'hF, 32'h0000_0080);
        rd_chk(BASE + 32'h0000_0140, 4'hE, 32'h0000_0080);
        wr(32'h0001_0140, 4'hF, 32'hFFFF_FFFF);
        rd_chk(BASE + 32'h0000_0140, 4'h1, 32'h0000_0080);
        for (int i = 0; i < 4; i++) begin
            ref_m[i] = 32'h0000_0000;
            wr(BASE + 32'(4 * i), 4'hF, 32'h1357_9BDF * 32'(i + 1));
        end
        for (int i = 0; i < 4; i++) begin
            wr(BASE, 4'(1 << i), 32'hA5C3_0F69 ^ 32'(i));
            rd_chk(BASE, 4'hF, ref_m[0]);
        end
        wr(BASE + 32'h0000_0004, 4'h0, 32'hFFFF_FFFF);
        for (int i = 0; i < 4; i++) begin
            rd_chk(BASE + 32'(4 * i), 4'hF, ref_m[i]);
            rd_chk(BASE + 32'h0000_0004, 4'(1 << i), ref_m[1]);
        end
        rd_chk(BASE + 32'h0000_000C, 4'h0, 32'h0000_0000);
        d = ref_m[2];
        rd_chk(BASE + 32'h0000_1008, 4'hF, d);
        wr(BASE + 32'h0000_100C, 4'h6, 32'h0BAD_F00D);
        rd_chk(BASE + 32'h0000_000C, 4'hF, ref_m[3]);
        repeat (4) @(posedge sys_clk);
        #10;
        check(32'(n_acc), 32'(n_xfer));
        check(32'(n_sync), 32'(n_xfer));
        stop_test();
    end
endmodule : tb_top
